//--- inc/ppcb_pkg.sv
/*
  Constants for the port pin configuration bank: special function register
  addresses, pages, implemented-bit masks and reset values.
  Assumes an 8-bit special function register bus with paged addressing.
*/
package ppcb_pkg;
  // ----------------------------------------------------------------------
  // Register addresses and pages.
  // ----------------------------------------------------------------------
  localparam logic [7:0] PPCB_ADDR_P2_DRV   = 8'hA6;
  localparam logic [7:0] PPCB_ADDR_P3_LATCH = 8'hB0;
  localparam logic [7:0] PPCB_ADDR_P2_SKIP  = 8'hCC;
  localparam logic [7:0] PPCB_ADDR_P3_INSEL = 8'hF4;
  localparam logic [7:0] PPCB_PAGE_0        = 8'h00;
  localparam logic [7:0] PPCB_PAGE_20       = 8'h20;
  // ----------------------------------------------------------------------
  // Implemented-bit masks.
  // ----------------------------------------------------------------------
  localparam logic [7:0] PPCB_MASK_P2_DRV   = 8'h7F;
  localparam logic [7:0] PPCB_MASK_P2_SKIP  = 8'h0F;
  localparam logic [7:0] PPCB_MASK_P3       = 8'h9F;
  // ----------------------------------------------------------------------
  // Reset values and fixed reserved-bit values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] PPCB_RST_P2_DRV    = 8'h00;
  localparam logic [7:0] PPCB_RST_P2_SKIP   = 8'h00;
  localparam logic [7:0] PPCB_RST_P3_LATCH  = 8'h9F;
  localparam logic [7:0] PPCB_RST_P3_INSEL  = 8'h9F;
  localparam logic [7:0] PPCB_RSV_P3_INSEL  = 8'h60;
  localparam logic [7:0] PPCB_ZERO          = 8'h00;
  // ----------------------------------------------------------------------
  // Bit-address field layout.
  // ----------------------------------------------------------------------
  localparam int         PPCB_BIT_IDX_W     = 3;
endpackage

//--- design/ppcb_port_bank.sv
/*
  Port 2 driver-style and crossbar-skip bits, port 3 latch, readback and
  analog/digital input select, reached over the special function register bus.
  Assumes one 20 MHz clock, pin levels synchronous to it, and port 3 output
  style supplied by the neighbouring output-mode register.
*/
`timescale 1ns/1ps
// Function
// - Port 2 driver bit 0 selects open-drain, 1 selects push-pull.
// - Port 2 driver bits reset to 0; bit 7 is read-only.
// - Port 2 skip bit 1 makes crossbar pass over pins 0 to 3.
// - Port 2 skip register sits at 0xCC page 0x20; bits 7:4 read zero.
// - Port 3 data writes change the latch only for digital pins.
// - Port 3 data reads return the pin levels, not the latch.
// - Port 3 latch bit 0 drives the pin low.
// - Latch 1 drives high or floats in open-drain; latch resets to 1.
// - Port 3 data sits at 0xB0 on every page, bit-addressable, bits 7,4:0.
// - Port 3 input select 0 is analog, 1 is digital.
// - Analog pins lose pull-up, output driver and input receiver.
// - Input select bits reset to 1; reserved bits 6:5 read-only.
// - Port 3 input select register sits at 0xF4 page 0x20.
module ppcb_port_bank (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic [7:0]                    sfr_page,
  input  wire logic [7:0]                    sfr_addr,
  input  wire logic                          sfr_wr,
  input  wire logic [7:0]                    sfr_wdata,
  input  wire logic                          sfr_rd,
  input  wire logic                          sfr_bit_wr,
  input  wire logic [7:0]                    sfr_bit_addr,
  input  wire logic                          sfr_bit_val,
  input  wire logic [7:0]                    p3_out_mode,
  input  wire logic [7:0]                    p3_pin_in,
  output logic      [7:0]                    sfr_rdata,
  output logic      [6:0]                    p2_push_pull,
  output logic      [3:0]                    p2_skip,
  output logic      [7:0]                    p3_pin_out,
  output logic      [7:0]                    p3_pin_oe_n,
  output logic      [7:0]                    p3_pullup_en,
  output logic      [7:0]                    p3_rx_en
);
  import ppcb_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  // Returns true when the access hits the given address on an allowed page.
  function automatic logic sfr_hit(input logic [7:0] page, input logic [7:0] addr,
                                   input logic [7:0] want, input logic any_page,
                                   input logic on_page0);
    sfr_hit = (addr == want) &&
              (any_page || (page == PPCB_PAGE_20) || (on_page0 && page == PPCB_PAGE_0));
  endfunction

  logic hit_drv;
  logic hit_skip;
  logic hit_latch;
  logic hit_insel;
  logic bit_hit;
  logic [PPCB_BIT_IDX_W-1:0] bit_idx;

  // Decodes each register window for the current access.
  always_comb begin
    hit_drv   = sfr_hit(sfr_page, sfr_addr, PPCB_ADDR_P2_DRV, 1'b0, 1'b1);
    hit_skip  = sfr_hit(sfr_page, sfr_addr, PPCB_ADDR_P2_SKIP, 1'b0, 1'b0);
    hit_latch = sfr_hit(sfr_page, sfr_addr, PPCB_ADDR_P3_LATCH, 1'b1, 1'b0);
    hit_insel = sfr_hit(sfr_page, sfr_addr, PPCB_ADDR_P3_INSEL, 1'b0, 1'b0);
    bit_idx   = sfr_bit_addr[PPCB_BIT_IDX_W-1:0];
    bit_hit   = sfr_bit_wr &&
                ({sfr_bit_addr[7:PPCB_BIT_IDX_W], 3'h0} == PPCB_ADDR_P3_LATCH);
  end

  // ----------------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------------
  logic [7:0] drv_q, drv_d;
  logic [7:0] skip_q, skip_d;
  logic [7:0] latch_q, latch_d;
  logic [7:0] insel_q, insel_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] wr_bits;
  logic [7:0] wr_mask;

  // Computes register updates; reserved bits are held by the masks.
  always_comb begin
    drv_d   = drv_q;
    skip_d  = skip_q;
    latch_d = latch_q;
    insel_d = insel_q;
    wr_bits = sfr_wdata;
    wr_mask = PPCB_ZERO;
    if (sfr_wr && hit_drv) begin
      drv_d = sfr_wdata & PPCB_MASK_P2_DRV;
    end
    if (sfr_wr && hit_skip) begin
      skip_d = sfr_wdata & PPCB_MASK_P2_SKIP;
    end
    if (sfr_wr && hit_insel) begin
      insel_d = sfr_wdata & PPCB_MASK_P3;
    end
    if (sfr_wr && hit_latch) begin
      wr_mask = PPCB_MASK_P3;
    end else if (bit_hit) begin
      wr_mask = PPCB_MASK_P3 & (8'h01 << bit_idx);
      wr_bits = {8{sfr_bit_val}};
    end
    wr_mask = wr_mask & insel_q;
    latch_d = (latch_q & ~wr_mask) | (wr_bits & wr_mask);
    rdata_d = rdata_q;
    if (sfr_rd) begin
      if (hit_drv) begin
        rdata_d = drv_q;
      end else if (hit_skip) begin
        rdata_d = skip_q;
      end else if (hit_latch) begin
        rdata_d = p3_pin_in & PPCB_MASK_P3 & insel_q;
      end else if (hit_insel) begin
        rdata_d = insel_q | PPCB_RSV_P3_INSEL;
      end else begin
        rdata_d = PPCB_ZERO;
      end
    end
  end

  // Registers the configuration state and read data.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      drv_q   <= PPCB_RST_P2_DRV;
      skip_q  <= PPCB_RST_P2_SKIP;
      latch_q <= PPCB_RST_P3_LATCH;
      insel_q <= PPCB_RST_P3_INSEL;
      rdata_q <= PPCB_ZERO;
    end else begin
      drv_q   <= drv_d;
      skip_q  <= skip_d;
      latch_q <= latch_d;
      insel_q <= insel_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive stage.
  // ----------------------------------------------------------------------
  logic [7:0] pout_d, poe_n_d, pup_d, prx_d;
  logic [7:0] pout_q, poe_n_q, pup_q, prx_q;
  logic [6:0] p2pp_q;
  logic [3:0] port2_crossbar_skip_q;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // Works out drive, pull-up and receiver for one port 3 pin.
      always_comb begin
        if (PPCB_MASK_P3[gi] && insel_q[gi]) begin
          pout_d[gi]  = latch_q[gi];
          poe_n_d[gi] = latch_q[gi] && !p3_out_mode[gi];
          pup_d[gi]   = 1'b1;
          prx_d[gi]   = 1'b1;
        end else begin
          pout_d[gi]  = 1'b0;
          poe_n_d[gi] = 1'b1;
          pup_d[gi]   = 1'b0;
          prx_d[gi]   = 1'b0;
        end
      end
    end
  endgenerate

  // Registers every pin-facing output.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pout_q   <= PPCB_ZERO;
      poe_n_q  <= 8'hFF;
      pup_q    <= PPCB_ZERO;
      prx_q    <= PPCB_ZERO;
      p2pp_q   <= 7'h00;
      port2_crossbar_skip_q <= 4'h0;
    end else begin
      pout_q   <= pout_d;
      poe_n_q  <= poe_n_d;
      pup_q    <= pup_d;
      prx_q    <= prx_d;
      p2pp_q   <= drv_q[6:0];
      port2_crossbar_skip_q <= skip_q[3:0];
    end
  end

  assign sfr_rdata    = rdata_q;
  assign p2_push_pull = p2pp_q;
  assign p2_skip      = port2_crossbar_skip_q;
  assign p3_pin_out   = pout_q;
  assign p3_pin_oe_n  = poe_n_q;
  assign p3_pullup_en = pup_q;
  assign p3_rx_en     = prx_q;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_skip_write;
    sfr_wr && sfr_page == PPCB_PAGE_20 && sfr_addr == PPCB_ADDR_P2_SKIP;
  endsequence
  sequence s_skip_seen;
    ##2 p2_skip == $past(sfr_wdata[3:0], 2);
  endsequence

  property p_drv_follow;
    p2_push_pull == $past(drv_q[6:0]);
  endproperty
  a_drv_follow: assert property (p_drv_follow) else $error("driver style output lags wrongly");

  property p_drv_rsv;
    drv_q[7] == 1'b0;
  endproperty
  a_drv_rsv: assert property (p_drv_rsv) else $error("driver register bit 7 set");

  property p_skip_path;
    s_skip_write |-> s_skip_seen;
  endproperty
  a_skip_path: assert property (p_skip_path) else $error("skip write not seen at pins");

  property p_latch_analog;
    !insel_q[0] |=> latch_q[0] == $past(latch_q[0]);
  endproperty
  a_latch_analog: assert property (p_latch_analog) else $error("analog pin latch changed");

  property p_read_pin;
    sfr_rd && sfr_addr == PPCB_ADDR_P3_LATCH |=> sfr_rdata == ($past(p3_pin_in) & PPCB_MASK_P3 & $past(insel_q));
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("port 3 read not pin level");

  property p_drive_low;
    insel_q[2] && !latch_q[2] |=> !p3_pin_oe_n[2] && !p3_pin_out[2];
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("latch zero not driving low");

  property p_od_float;
    insel_q[3] && latch_q[3] && !p3_out_mode[3] |=> p3_pin_oe_n[3];
  endproperty
  a_od_float: assert property (p_od_float) else $error("open-drain high not released");

  property p_analog_off;
    !insel_q[4] |=> p3_pin_oe_n[4] && !p3_pullup_en[4] && !p3_rx_en[4];
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin left active");

  property p_insel_read;
    sfr_rd && sfr_page == PPCB_PAGE_20 && sfr_addr == PPCB_ADDR_P3_INSEL |=> sfr_rdata[6:5] == 2'b11;
  endproperty
  a_insel_read: assert property (p_insel_read) else $error("input select reserved bits wrong");
endmodule

//--- verif/ppcb_pin_model.sv
/*
  Pad model for port 3: works out each pad level from the bank's driver,
  its weak pull-up and an outside source that the bench controls.
  Assumes one pad per bit and that the outside source never fights a driver.
*/
`timescale 1ns/1ps
module ppcb_pin_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] p3_pin_out,
  input  wire logic [7:0] p3_pin_oe_n,
  input  wire logic [7:0] p3_pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] p3_pin_in
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  logic [7:0] float_q = 8'h55;
  // An undriven pad with no pull-up wanders, so it flips away from the clock edge.
  always @(negedge clk_sys) begin
    float_q <= ~float_q;
  end
  // The driver wins, then the outside source, then the weak pull-up.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!p3_pin_oe_n[i]) begin
        p3_pin_in[i] = p3_pin_out[i];
      end else if (ext_en[i]) begin
        p3_pin_in[i] = ext_val[i];
      end else if (p3_pullup_en[i]) begin
        p3_pin_in[i] = 1'b1;
      end else begin
        p3_pin_in[i] = float_q[i];
      end
    end
  end
endmodule

//--- verif/tb_top.sv
/*
  Self-checking bench for the port pin configuration bank.
  Assumes the bank's register timing of one cycle to read data and one
  cycle from a register change to the pin outputs.
*/
`timescale 1ns/1ps
module tb_top;
  import ppcb_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
  logic [7:0] sfr_bit_addr = 8'h00, p3_out_mode = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [7:0] p3_pin_in, sfr_rdata, p3_pin_out, p3_pin_oe_n, p3_pullup_en, p3_rx_en;
  logic [6:0] p2_push_pull;
  logic [3:0] p2_skip;
  int         mismatches = 0;
  int         samples_checked = 0;

  // Clock of 50 ns period.
  always #25 clk_sys = ~clk_sys;

  ppcb_port_bank uut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val), .p3_out_mode(p3_out_mode),
    .p3_pin_in(p3_pin_in), .sfr_rdata(sfr_rdata), .p2_push_pull(p2_push_pull), .p2_skip(p2_skip),
    .p3_pin_out(p3_pin_out), .p3_pin_oe_n(p3_pin_oe_n), .p3_pullup_en(p3_pullup_en), .p3_rx_en(p3_rx_en));

  ppcb_pin_model pads (.clk_sys(clk_sys), .p3_pin_out(p3_pin_out), .p3_pin_oe_n(p3_pin_oe_n),
    .p3_pullup_en(p3_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .p3_pin_in(p3_pin_in));

  // Compares one value and reports a difference at once.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // Byte write, then one idle cycle so the pin outputs have settled.
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_page = pg;
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  // Single-bit write on port 3.
  task automatic bwr(input logic [7:0] ba, input logic v);
    @(negedge clk_sys);
    sfr_bit_addr = ba;
    sfr_bit_val = v;
    sfr_bit_wr = 1'b1;
    @(negedge clk_sys);
    sfr_bit_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  // Byte read; data is looked at half a cycle after the strobe is taken, on the next falling edge.
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp, input string name);
    @(negedge clk_sys);
    sfr_page = pg;
    sfr_addr = ad;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk(name, exp, sfr_rdata);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #(3000 * 50);
    mismatches++;
    results();
  end

  // Main sequence.
  initial begin
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("p2_push_pull", 8'h00, {1'b0, p2_push_pull});
    chk("p2_skip", 8'h00, {4'h0, p2_skip});
    chk("pullup", 8'h9F, p3_pullup_en);
    chk("oe_n", 8'hFF, p3_pin_oe_n);
    rd(PPCB_PAGE_20, PPCB_ADDR_P3_INSEL, 8'hFF, "insel");
    $display("test reset done");
    wr(PPCB_PAGE_20, PPCB_ADDR_P2_DRV, 8'hFF);
    chk("p2_push_pull", 8'h7F, {1'b0, p2_push_pull});
    rd(PPCB_PAGE_0, PPCB_ADDR_P2_DRV, 8'h7F, "drv");
    wr(PPCB_PAGE_0, PPCB_ADDR_P2_DRV, 8'h2A);
    chk("p2_push_pull", 8'h2A, {1'b0, p2_push_pull});
    wr(PPCB_PAGE_20, PPCB_ADDR_P2_SKIP, 8'hF5);
    chk("p2_skip", 8'h05, {4'h0, p2_skip});
    wr(PPCB_PAGE_0, PPCB_ADDR_P2_SKIP, 8'h0A);
    rd(PPCB_PAGE_20, PPCB_ADDR_P2_SKIP, 8'h05, "skip");
    rd(PPCB_PAGE_0, PPCB_ADDR_P2_SKIP, 8'h00, "skip_page0");
    $display("test port2 done");
    p3_out_mode = 8'h9F;
    wr(8'h10, PPCB_ADDR_P3_LATCH, 8'h00);
    chk("oe_n", 8'h60, p3_pin_oe_n);
    chk("pin_out", 8'h00, p3_pin_out);
    rd(8'h10, PPCB_ADDR_P3_LATCH, 8'h00, "p3_low");
    p3_out_mode = 8'h00;
    ext_en = 8'h08;
    wr(PPCB_PAGE_20, PPCB_ADDR_P3_LATCH, 8'h9F);
    chk("oe_n", 8'hFF, p3_pin_oe_n);
    rd(PPCB_PAGE_0, PPCB_ADDR_P3_LATCH, 8'h97, "p3_pins");
    bwr(8'hB2, 1'b0);
    rd(PPCB_PAGE_0, PPCB_ADDR_P3_LATCH, 8'h93, "p3_bit");
    ext_en = 8'h00;
    $display("test port3 latch done");
    wr(PPCB_PAGE_20, PPCB_ADDR_P3_INSEL, 8'hFE);
    chk("rx_en", 8'h9E, p3_rx_en);
    chk("pullup", 8'h9E, p3_pullup_en);
    rd(PPCB_PAGE_20, PPCB_ADDR_P3_INSEL, 8'hFE, "insel");
    wr(PPCB_PAGE_20, PPCB_ADDR_P3_LATCH, 8'h80);
    rd(PPCB_PAGE_20, PPCB_ADDR_P3_LATCH, 8'h80, "p3_analog");
    wr(PPCB_PAGE_20, PPCB_ADDR_P3_INSEL, 8'hFF);
    chk("oe_n", 8'hE1, p3_pin_oe_n);
    chk("pin_out", 8'h81, p3_pin_out);
    rd(PPCB_PAGE_20, PPCB_ADDR_P3_LATCH, 8'h81, "p3_digital");
    // Pin 7 switched to push-pull now drives its high latch value.
    p3_out_mode = 8'h80;
    repeat (2) @(negedge clk_sys);
    chk("oe_n", 8'h61, p3_pin_oe_n);
    rd(PPCB_PAGE_20, PPCB_ADDR_P3_LATCH, 8'h81, "p3_push_pull");
    $display("test input mode done");
    results();
  end
endmodule
